// [rtl/scru_pkg.sv]
package scru_pkg;

    // Register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_CLOCK_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_LOCAL_BUS_CLOCK_CONTROL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SYSTEM_CLOCK_CONTROL = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RESET_CONFIG_WORD_LOW = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_RATIO_STATUS = 5'h10;

    // Bus clock outputs and configurable units
    localparam int NUM_BUS_CLK_OUT = 3;
    localparam int NUM_UNITS = 5;
    localparam int UNIT_SECURITY = 2;
    localparam int UNIT_SERIAL_BUS = 3;
    localparam int UNIT_BUS_COMPLEX = 4;

    // Per-unit clock modes
    localparam logic [1:0] UMODE_OFF = 2'h0;
    localparam logic [1:0] UMODE_FULL = 2'h1;
    localparam logic [1:0] UMODE_DIV2 = 2'h2;
    localparam logic [1:0] UMODE_DIV3 = 2'h3;
    localparam logic [1:0] UCNT_DIV2_LAST = 2'h1;
    localparam logic [1:0] UCNT_DIV3_LAST = 2'h2;
    localparam logic [2*NUM_UNITS-1:0] SCC_RESET = 10'h155;

    // Local bus divider field encodings
    localparam logic [1:0] LDIV_2 = 2'h0;
    localparam logic [1:0] LDIV_4 = 2'h1;
    localparam logic [1:0] LDIV_8 = 2'h2;
    localparam logic [1:0] LCC_RESET = 2'h0;
    localparam logic [3:0] LDIV_VAL_2 = 4'h2;
    localparam logic [3:0] LDIV_VAL_4 = 4'h4;
    localparam logic [3:0] LDIV_VAL_8 = 4'h8;

    // Reset configuration word low field layout
    localparam int RCW_LBCR_BIT = 0;
    localparam int RCW_MCR_BIT = 1;
    localparam int RCW_SLF_LO = 4;
    localparam int RCW_SLF_HI = 7;
    localparam int RCW_CORE_LO = 8;
    localparam int RCW_CORE_HI = 14;

    // Built-in reset configuration options; values arbitrary
    localparam logic [DATA_W-1:0] RCW_BUILTIN_1 = 32'h0000_0240;
    localparam logic [DATA_W-1:0] RCW_BUILTIN_2 = 32'h0000_0431;
    localparam logic [DATA_W-1:0] RCW_BUILTIN_3 = 32'h0000_0350;

    // System loop factor legal range
    localparam logic [3:0] SLF_MIN = 4'h2;
    localparam logic [3:0] SLF_MAX = 4'h6;

    // Core loop select decode
    localparam logic [1:0] CORE_VCO_BAD = 2'h3;
    localparam logic [3:0] CORE_MID_BYPASS = 4'h0;
    localparam logic [3:0] CORE_MID_MAX = 4'h3;
    localparam logic [3:0] CORE_HALVES_BYPASS = 4'h2;

    // Status field positions
    localparam int ST_SLF_LO = 0;
    localparam int ST_CORE_LO = 4;
    localparam int ST_CSB_LO = 8;
    localparam int ST_MEM_LO = 12;
    localparam int ST_LBC_LO = 14;
    localparam int ST_LDIV_LO = 16;
    localparam int ST_BYPASS_BIT = 20;
    localparam int ST_SLF_RSV_BIT = 21;
    localparam int ST_CORE_RSV_BIT = 22;
    localparam int ST_HOST_BIT = 23;
    localparam int ST_HALVE_BIT = 24;
    localparam int ST_LOADED_BIT = 25;

    // Cycles the strap synchronisers need before capture
    localparam logic [1:0] CAPTURE_DONE = 2'h3;

    // Avalon request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } scru_avm_req_s;

    // Clock enable strobes, one pulse per output clock period
    typedef struct packed {
        logic sync_out;
        logic [NUM_BUS_CLK_OUT-1:0] bus_out;
        logic memory_bus;
        logic local_bus_out;
        logic [NUM_UNITS-1:0] unit;
    } scru_clk_en_s;

endpackage

// [rtl/scru_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module scru_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] stage1;

    // Two flip-flops; the first is read only by the second
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule
`default_nettype wire

// [rtl/scru_ratio_div.sv]
`timescale 1ns/1ps
`default_nettype none
module scru_ratio_div (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Requested mode, enable strobe out
    input wire logic [1:0] i_mode,
    output logic o_en
);
    import scru_pkg::*;

    logic [1:0] cur_mode;
    logic [1:0] cnt;
    logic boundary;
    logic [1:0] last;

    // Last count of the current period
    always_comb begin
        unique case (cur_mode)
            UMODE_DIV2: last = UCNT_DIV2_LAST;
            UMODE_DIV3: last = UCNT_DIV3_LAST;
            default: last = '0;
        endcase
    end

    assign boundary = (cnt == last);

    // New mode taken only at a period boundary, never mid-pulse
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            cur_mode <= UMODE_FULL;
            cnt <= '0;
        end else if (boundary) begin
            cur_mode <= i_mode;
            cnt <= '0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end

    // One strobe per whole period of the selected rate
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_en <= 1'b0;
        end else begin
            o_en <= (cur_mode != UMODE_OFF) && (cnt == '0);
        end
    end

    chk_mode_stable_midperiod: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !boundary |=> $stable(cur_mode))
        else $error("Unit mode changed inside a period");

endmodule
`default_nettype wire

// [rtl/scru_top.sv]
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scru_top (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Straps and reset configuration
    input wire logic i_host_mode_strap,
    input wire logic i_input_divide_strap,
    input wire logic [1:0] i_reset_config_source,
    input wire logic [scru_pkg::DATA_W-1:0] i_reset_config_word_low,
    // Avalon-MM slave
    input wire scru_pkg::scru_avm_req_s i_avm,
    output logic [scru_pkg::DATA_W-1:0] o_avm_readdata,
    output logic o_avm_waitrequest,
    // Clock strobes and status
    output scru_pkg::scru_clk_en_s o_clk_en,
    output logic o_memory_bus_clock_p,
    output logic o_memory_bus_clock_n,
    output logic o_primary_is_host,
    output logic [scru_pkg::DATA_W-1:0] o_ratio_status
);
    import scru_pkg::*;

    // Decoded core factor in half units, with reserved and bypass flags
    function automatic logic [5:0] core_decode(input logic [6:0] f);
        logic [1:0] vco;
        logic [3:0] mid;
        logic frac;
        logic [3:0] halves;
        logic rsv;
        logic byp;
        vco = f[6:5];
        mid = f[4:1];
        frac = f[0];
        byp = 1'b0;
        rsv = 1'b0;
        halves = '0;
        if (mid == CORE_MID_BYPASS) begin
            byp = 1'b1;
            halves = CORE_HALVES_BYPASS;
        end else if (vco == CORE_VCO_BAD || mid > CORE_MID_MAX
                     || (mid == CORE_MID_MAX && frac)) begin
            rsv = 1'b1;
        end else begin
            halves = {mid[2:0], frac};
        end
        return {rsv, byp, halves};
    endfunction

    // Synchronised straps and configuration pins
    logic [1:0] straps_s;
    logic [1:0] src_s;
    logic [DATA_W-1:0] rcw_pins_s;
    logic [1:0] cap_cnt;
    logic loaded;
    logic host_mode;
    logic halve;
    logic [DATA_W-1:0] rcw;
    logic [3:0] slf;
    logic slf_rsv;
    logic [5:0] core_dec;
    logic lbc_ratio;
    logic mem_ratio;

    scru_sync #(.W(2)) u_sync_straps (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_async({i_host_mode_strap, i_input_divide_strap}),
        .o_sync(straps_s)
    );

    scru_sync #(.W(2 + DATA_W)) u_sync_rcw (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_async({i_reset_config_source, i_reset_config_word_low}),
        .o_sync({src_s, rcw_pins_s})
    );

    // Configuration captured once the synchronisers have settled after release
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            cap_cnt <= '0;
            loaded <= 1'b0;
            host_mode <= 1'b0;
            halve <= 1'b0;
            rcw <= '0;
        end else if (cap_cnt != CAPTURE_DONE) begin
            cap_cnt <= cap_cnt + 2'h1;
            loaded <= (cap_cnt == CAPTURE_DONE - 2'h1);
            host_mode <= straps_s[1];
            halve <= straps_s[0];
            unique case (src_s)
                2'h0: rcw <= rcw_pins_s;
                2'h1: rcw <= RCW_BUILTIN_1;
                2'h2: rcw <= RCW_BUILTIN_2;
                2'h3: rcw <= RCW_BUILTIN_3;
            endcase
        end
    end

    // Field extraction
    assign slf = rcw[RCW_SLF_HI:RCW_SLF_LO];
    assign slf_rsv = (slf < SLF_MIN) || (slf > SLF_MAX);
    assign core_dec = core_decode(rcw[RCW_CORE_HI:RCW_CORE_LO]);
    assign lbc_ratio = rcw[RCW_LBCR_BIT];
    assign mem_ratio = rcw[RCW_MCR_BIT];
    assign o_primary_is_host = host_mode;

    // Software registers
    logic [NUM_BUS_CLK_OUT-1:0] output_clock_control;
    logic [1:0] local_bus_clock_control;
    logic [2*NUM_UNITS-1:0] system_clock_control;
    logic ack;
    logic wr_fire;
    logic [DATA_W-1:0] status_word;

    // One wait state per access
    assign o_avm_waitrequest = !ack;
    assign wr_fire = i_avm.write && ack;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= (i_avm.read || i_avm.write) && !ack;
        end
    end

    // Register writes take effect on the accepting edge
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            output_clock_control <= '0;
            local_bus_clock_control <= LCC_RESET;
            system_clock_control <= SCC_RESET;
        end else if (wr_fire) begin
            unique case (i_avm.address)
                OFS_OUTPUT_CLOCK_CONTROL:
                    output_clock_control <= i_avm.writedata[NUM_BUS_CLK_OUT-1:0];
                OFS_LOCAL_BUS_CLOCK_CONTROL:
                    local_bus_clock_control <= i_avm.writedata[1:0];
                OFS_SYSTEM_CLOCK_CONTROL:
                    system_clock_control <= i_avm.writedata[2*NUM_UNITS-1:0];
                default: ;
            endcase
        end
    end

    // Ratio status word
    always_comb begin
        status_word = '0;
        status_word[ST_SLF_LO +: 4] = slf_rsv ? 4'h0 : slf;
        status_word[ST_CORE_LO +: 4] = core_dec[3:0];
        status_word[ST_CSB_LO +: 4] = (slf_rsv ? 4'h0 : slf) << halve;
        status_word[ST_MEM_LO +: 2] = {mem_ratio, !mem_ratio};
        status_word[ST_LBC_LO +: 2] = {lbc_ratio, !lbc_ratio};
        status_word[ST_LDIV_LO +: 4] = ldiv_val(local_bus_clock_control);
        status_word[ST_BYPASS_BIT] = core_dec[4];
        status_word[ST_SLF_RSV_BIT] = slf_rsv;
        status_word[ST_CORE_RSV_BIT] = core_dec[5];
        status_word[ST_HOST_BIT] = host_mode;
        status_word[ST_HALVE_BIT] = halve;
        status_word[ST_LOADED_BIT] = loaded;
    end

    assign o_ratio_status = status_word;

    // Read data loaded in the wait cycle, stands at the accepting edge
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_avm_readdata <= '0;
        end else if (i_avm.read && !ack) begin
            unique case (i_avm.address)
                OFS_OUTPUT_CLOCK_CONTROL:
                    o_avm_readdata <= DATA_W'(output_clock_control);
                OFS_LOCAL_BUS_CLOCK_CONTROL:
                    o_avm_readdata <= DATA_W'(local_bus_clock_control);
                OFS_SYSTEM_CLOCK_CONTROL:
                    o_avm_readdata <= DATA_W'(system_clock_control);
                OFS_RESET_CONFIG_WORD_LOW: o_avm_readdata <= rcw;
                OFS_RATIO_STATUS: o_avm_readdata <= status_word;
                default: o_avm_readdata <= '0;
            endcase
        end
    end

    // Divider value for the local bus divider field
    function automatic logic [3:0] ldiv_val(input logic [1:0] sel);
        unique case (sel)
            LDIV_2: return LDIV_VAL_2;
            LDIV_4: return LDIV_VAL_4;
            default: return LDIV_VAL_8;
        endcase
    endfunction

    // Sync output strobe, in host mode only: every cycle, or every other when halved
    logic sync_phase;
    logic sync_en;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sync_phase <= 1'b0;
            sync_en <= 1'b0;
        end else begin
            sync_phase <= !sync_phase;
            sync_en <= host_mode && loaded && (!halve || !sync_phase);
        end
    end

    // Memory pair: internal ticks accumulated, one strobe and one pair toggle per two ticks
    logic [1:0] mem_acc;
    logic mem_en;
    logic [1:0] mem_sum;

    assign mem_sum = mem_acc + {1'b0, loaded} + {1'b0, loaded && mem_ratio};

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            mem_acc <= '0;
            mem_en <= 1'b0;
            o_memory_bus_clock_p <= 1'b0;
        end else if (mem_sum >= 2'h2) begin
            mem_acc <= mem_sum - 2'h2;
            mem_en <= 1'b1;
            o_memory_bus_clock_p <= !o_memory_bus_clock_p;
        end else begin
            mem_acc <= mem_sum;
            mem_en <= 1'b0;
        end
    end

    assign o_memory_bus_clock_n = !o_memory_bus_clock_p;

    // Local bus out: local internal ticks divided by the selected value
    logic [3:0] lb_acc;
    logic [3:0] lb_sum;
    logic [3:0] lb_div;
    logic lb_en;

    assign lb_div = ldiv_val(local_bus_clock_control);
    assign lb_sum = lb_acc + {3'h0, loaded} + {3'h0, loaded && lbc_ratio};

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            lb_acc <= '0;
            lb_en <= 1'b0;
        end else if (lb_sum >= lb_div) begin
            // Restart the count when a smaller divider leaves it past the end
            lb_acc <= (lb_acc >= lb_div) ? '0 : lb_sum - lb_div;
            lb_en <= 1'b1;
        end else begin
            lb_acc <= lb_sum;
            lb_en <= 1'b0;
        end
    end

    // Per-unit glitch-free ratio dividers
    logic [NUM_UNITS-1:0] unit_en;
    logic [1:0] unit_mode [NUM_UNITS];

    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        // Bus complex has only off or full rate
        if (u == UNIT_BUS_COMPLEX) begin : g_cplx
            assign unit_mode[u] = (system_clock_control[2*u +: 2] == UMODE_OFF)
                                  ? UMODE_OFF : UMODE_FULL;
        end else begin : g_norm
            assign unit_mode[u] = system_clock_control[2*u +: 2];
        end
        scru_ratio_div u_div (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_mode(unit_mode[u]),
            .o_en(unit_en[u])
        );
    end

    // Collected strobes
    assign o_clk_en.sync_out = sync_en;
    assign o_clk_en.bus_out = {NUM_BUS_CLK_OUT{sync_en}} & output_clock_control;
    assign o_clk_en.memory_bus = mem_en;
    assign o_clk_en.local_bus_out = lb_en;
    assign o_clk_en.unit = unit_en;

    // Checks
    chk_agent_no_sync: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !host_mode |-> !o_clk_en.sync_out)
        else $error("Sync output active in agent mode");
    chk_sync_halved: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (sync_en && halve && $stable(halve)) |=> !sync_en)
        else $error("Halved sync strobe too fast");
    chk_bus_out_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (|o_clk_en.bus_out) |-> (sync_en && |output_clock_control))
        else $error("Bus clock out without enable");
    chk_csb_ratio: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!slf_rsv && halve) |-> (status_word[ST_CSB_LO +: 4] == {slf[2:0], 1'b0}))
        else $error("System bus ratio wrong");
    chk_slf_range: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (slf == SLF_MIN) |-> !slf_rsv ##0 (status_word[ST_SLF_LO +: 4] == 4'h2))
        else $error("Loop factor decode wrong");
    chk_core_bypass: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (rcw[RCW_CORE_LO+1 +: 4] == CORE_MID_BYPASS) |-> (core_dec[4] && core_dec[3:0] == 4'h2))
        else $error("Core bypass not reported");
    chk_rcw_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        loaded |=> $stable(rcw))
        else $error("Config word changed after load");
    chk_mem_full: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (loaded && mem_ratio && $stable(mem_ratio) && $past(loaded)) |=> mem_en)
        else $error("Memory pair not at bus rate");
    chk_local_div2: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (lb_en && !lbc_ratio && local_bus_clock_control == LDIV_2
         && $stable(local_bus_clock_control)) |=> !lb_en)
        else $error("Local bus out too fast");
    chk_unit_reset_full: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(i_nrst) |-> ##2 (&unit_en))
        else $error("Units not at full rate after reset");

    cov_host_halved: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        host_mode && halve && sync_en);
    cov_unit_div3: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        system_clock_control[1:0] == UMODE_DIV3 && unit_en[0]);
    cov_local_div8: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        local_bus_clock_control == LDIV_8 && lb_en);
    cov_write_ack: cover property (@(posedge i_mclk) disable iff (!i_nrst) wr_fire);

endmodule
`default_nettype wire

// [testbench/scru_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scru_board_model (
    // Scenario select from the bench
    input wire logic [2:0] i_sel,
    // Straps and configuration pins
    output logic o_host_mode_strap,
    output logic o_input_divide_strap,
    output logic [1:0] o_source,
    output logic [31:0] o_word
);
    // Board strap table: host, halve, word source, word pins
    always_comb begin
        case (i_sel)
            3'h0: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'hc, 32'h0000_0543};
            3'h1: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'h0, 32'h0000_2020};
            3'h2: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'h8, 32'h0000_6272};
            3'h3: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'hd, 32'hffff_ffff};
            3'h4: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'h6, 32'h0000_0000};
            default: {o_host_mode_strap, o_input_divide_strap, o_source, o_word} = {4'h3, 32'h0};
        endcase
    end
endmodule
`default_nettype wire

// [testbench/test_system_clock_ratio_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %0h exp %0h", $time, (g), (e)); end end
module test_system_clock_ratio_unit;
    import scru_pkg::*;
    logic i_mclk, i_nrst, host, halve, wreq, mp, mn, phost;
    logic [1:0] src;
    logic [2:0] sel;
    logic [31:0] pins, rdata, status, w, e, m, q;
    scru_avm_req_s i_avm;
    scru_clk_en_s en;
    int bad_count, compares, mingap, pairbad;
    int cnt[11];
    int ex[4] = '{0, 48, 24, 16};

    scru_board_model u_board (.i_sel(sel), .o_host_mode_strap(host),
        .o_input_divide_strap(halve), .o_source(src), .o_word(pins));
    scru_top u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_host_mode_strap(host),
        .i_input_divide_strap(halve), .i_reset_config_source(src),
        .i_reset_config_word_low(pins), .i_avm(i_avm), .o_avm_readdata(rdata),
        .o_avm_waitrequest(wreq), .o_clk_en(en), .o_memory_bus_clock_p(mp),
        .o_memory_bus_clock_n(mn), .o_primary_is_host(phost), .o_ratio_status(status));

    // Clock and watchdog
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (30000) @(posedge i_mclk);
        bad_count++;
        wrap_up();
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_avm <= '{read: rd, write: !rd, address: a, writedata: d};
        do begin
            @(posedge i_mclk);
            n++;
        end while (wreq !== 1'b0);
        q = rdata;
        `CHK(n, 2)
        i_avm <= '0;
        @(posedge i_mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rdck(input logic [4:0] a, input logic [31:0] x);
        bus(1'b1, a, 32'h0);
        `CHK(q, x)
    endtask

    function automatic int b(input logic v);
        return (v === 1'b1) ? 1 : 0;
    endfunction

    // Strobe counts over a 48-cycle window
    task automatic count_win();
        int last;
        last = -1;
        mingap = 99;
        pairbad = 0;
        cnt = '{default: 0};
        for (int c = 0; c < 48; c++) begin
            @(posedge i_mclk);
            #1;
            cnt[0] += b(en.sync_out);
            for (int k = 0; k < 3; k++) cnt[1+k] += b(en.bus_out[k]);
            cnt[4] += b(en.memory_bus);
            cnt[5] += b(en.local_bus_out);
            for (int k = 0; k < 5; k++) cnt[6+k] += b(en.unit[k]);
            if (mp === mn) pairbad++;
            if (en.unit[0] === 1'b1) begin
                if (last >= 0 && c - last < mingap) mingap = c - last;
                last = c;
            end
        end
    endtask

    task automatic do_reset(input logic [2:0] s);
        i_nrst <= 1'b0;
        sel <= s;
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_mclk);
    endtask

    // Expected status from the captured word; core field masked when reserved
    function automatic logic [31:0] exp_st(input logic [31:0] x, input logic h, input logic hv);
        logic [3:0] f;
        logic [3:0] mid;
        logic rs, cr, byp;
        f = x[7:4];
        rs = f < 4'h2 || f > 4'h6;
        if (rs) f = 4'h0;
        mid = x[12:9];
        byp = mid == 4'h0;
        cr = !byp && (x[14:13] == 2'h3 || mid > 4'h3 || (mid == 4'h3 && x[8]));
        exp_st = '0;
        exp_st[3:0] = f;
        exp_st[7:4] = byp ? 4'h2 : {mid[2:0], x[8]};
        exp_st[11:8] = f << hv;
        exp_st[13:12] = 2'h1 + x[1];
        exp_st[15:14] = 2'h1 + x[0];
        exp_st[19:16] = 4'h2;
        exp_st[25:20] = {1'b1, hv, h, cr, rs, byp};
        m = cr ? 32'hffff_ff0f : 32'hffff_ffff;
    endfunction

    initial begin
        i_nrst = 1'b0;
        sel = 3'h0;
        i_avm = '0;
        // Every strap set and word source, straight after reset
        for (int s = 0; s < 6; s++) begin
            do_reset(3'(s));
            w = (src == 2'h0) ? pins : (src == 2'h1) ? RCW_BUILTIN_1 :
                (src == 2'h2) ? RCW_BUILTIN_2 : RCW_BUILTIN_3;
            e = exp_st(w, host, halve);
            rdck(OFS_RESET_CONFIG_WORD_LOW, w);
            `CHK(status & m, e & m)
            `CHK(phost, host)
            rdck(OFS_OUTPUT_CLOCK_CONTROL, 32'h0);
            rdck(OFS_LOCAL_BUS_CLOCK_CONTROL, 32'h0);
            rdck(OFS_SYSTEM_CLOCK_CONTROL, 32'h155);
            count_win();
            `CHK(cnt[0], host ? (halve ? 24 : 48) : 0)
            `CHK(cnt[1] + cnt[2] + cnt[3], 0)
            `CHK(cnt[4], 24 * (1 + int'(w[1])))
            `CHK(pairbad, 0)
            `CHK(cnt[5], 24 * (1 + int'(w[0])))
            for (int k = 6; k < 11; k++) `CHK(cnt[k], 48)
        end
        // Output enables, unmapped and read-only places
        do_reset(3'h0);
        wr(OFS_OUTPUT_CLOCK_CONTROL, 32'h5);
        wr(5'h14, 32'hffff_ffff);
        rdck(5'h14, 32'h0);
        rdck(OFS_OUTPUT_CLOCK_CONTROL, 32'h5);
        wr(OFS_RESET_CONFIG_WORD_LOW, 32'h0);
        rdck(OFS_RESET_CONFIG_WORD_LOW, 32'h0000_0543);
        count_win();
        `CHK({cnt[1], cnt[2], cnt[3]}, {32'd24, 32'd0, 32'd24})
        // Every local bus divider code; internal clock is doubled here
        for (int c = 0; c < 4; c++) begin
            wr(OFS_LOCAL_BUS_CLOCK_CONTROL, 32'(c));
            count_win();
            `CHK(cnt[5], 96 / ((c == 3) ? 8 : (2 << c)))
            `CHK(status[19:16], 4'((c == 3) ? 8 : (2 << c)))
        end
        // Every unit mode, same code in all five units
        for (int c = 0; c < 4; c++) begin
            wr(OFS_SYSTEM_CLOCK_CONTROL, 32'({5{2'(c)}}));
            rdck(OFS_SYSTEM_CLOCK_CONTROL, 32'({5{2'(c)}}));
            count_win();
            for (int k = 6; k < 10; k++) `CHK(cnt[k], ex[c])
            `CHK(cnt[10], (c == 0) ? 0 : 48)
        end
        // Divide-by-three to divide-by-two while running: no short period
        wr(OFS_SYSTEM_CLOCK_CONTROL, 32'h3ff);
        fork
            count_win();
            wr(OFS_SYSTEM_CLOCK_CONTROL, 32'h2aa);
        join
        `CHK(mingap >= 2, 1'b1)
        wrap_up();
    end
endmodule
`default_nettype wire
